/* File: design/idw_table.sv */
// Identify-device parameter table with task-file style register port
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/10ps

// Overview of operation
// - Word 0 reads 848Ah in removable mode
// - Word 0 reads 045Ah in fixed-disk mode
// - Serial words 10-19 right justified, 20h padded
// - Model words 27-46 left justified, 20h padded
// - Words 7-8 hold 32-bit total sectors
// - Word 49 bits 13 and 10 clear
// - Word 49 bits 9 and 8 set
// - Word 51 upper byte reads 02h
// - Word 53 low three bits set
// - Words 57-58 equal low 32 bits of current C*H*S product
// - Word 47 gives max sectors per interrupt
// - Word 59: bit 8 set, low byte 0/1
// - Word 63 upper byte one-hot selected mode, zero for msel 3
// - Word 63 low byte cumulative mode support
// - Modes above MDMA2/PIO4 only in word 163
// - Word 64 bits 1,0 show PIO 4,3
// - Word 65 minimum MDMA cycle time
// - Word 66 not below word 65
// - Unsupported timing fields read zero
// - Word 67 PIO time not below word 68
// - Word 163 0012h fixed, 0000h removable
module idw_table
  import idw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Register port
  input wire idw_req_t req,
  output logic [15:0] rdata,
  // Transfer state
  output logic drq
);

  // Serial field character p (0..19), right justified
  function automatic logic [7:0] ser_ch(input int p);
    if (p >= 20 - SER_LEN)
      return SERIAL_TXT[8*(19-p) +: 8];
    return PAD_CHAR;
  endfunction

  // Model field character p (0..39), left justified
  function automatic logic [7:0] mod_ch(input int p);
    if (p < MOD_LEN)
      return MODEL_TXT[8*(MOD_LEN-1-p) +: 8];
    return PAD_CHAR;
  endfunction

  // Current capacity; only the low 32 bits are reported
  function automatic logic [31:0] cur_cap(input idw_cfg_t c);
    logic [47:0] full;
    full = 48'(c.ccyl) * 48'(c.chead) * 48'(c.cspt);
    return full[31:0];
  endfunction

  // One word of the table, first character in the high byte
  function automatic logic [15:0] id_word(input logic [7:0] w, input idw_cfg_t c);
    int i;
    logic [15:0] v;
    logic [31:0] cap;
    i = int'(w);
    v = 16'h0000;
    cap = cur_cap(c);
    if (i == 0)
      v = c.fixed ? W0_FIXED : W0_REMOVABLE;
    else if (i == 1)
      v = c.dcyl;
    else if (i == 3)
      v = c.dhead;
    else if (i == 6)
      v = c.dspt;
    else if (i == 7)
      v = c.tot[31:16];
    else if (i == 8)
      v = c.tot[15:0];
    else if (i >= 10 && i <= 19)
      v = {ser_ch(2*(i-10)), ser_ch(2*(i-10)+1)};
    else if (i >= 23 && i <= 26)
      v = FW_TXT[16*(26-i) +: 16];
    else if (i >= 27 && i <= 46)
      v = {mod_ch(2*(i-27)), mod_ch(2*(i-27)+1)};
    else if (i == 47)
      v = W47_MULT_MAX;
    else if (i == 49)
      v = W49_CAPS;
    else if (i == 51)
      v = W51_PIO;
    else if (i == 53)
      v = W53_VALID;
    else if (i == 54)
      v = c.ccyl;
    else if (i == 55)
      v = c.chead;
    else if (i == 56)
      v = c.cspt;
    else if (i == 57)
      v = cap[15:0];
    else if (i == 58)
      v = cap[31:16];
    else if (i == 59)
      v = {7'h00, 1'b1, 7'h00, c.mult};
    else if (i == 60)
      v = c.tot[15:0];
    else if (i == 61)
      v = c.tot[31:16];
    else if (i == 63)
      v = {5'h00, (c.msel == 2'h2), (c.msel == 2'h1), (c.msel == 2'h0),
           W63_SUPPORT};
    else if (i == 64)
      v = W64_PIO_ADV;
    else if (i == 65)
      v = MDMA_MIN_NS;
    else if (i == 66)
      v = MDMA_REC_NS;
    else if (i == 67)
      v = PIO_MIN_NS;
    else if (i == 68)
      v = PIO_IORDY_NS;
    else if (i == 163)
      v = c.fixed ? W163_FIXED : W163_REMOVABLE;
    return v;
  endfunction

  idw_cfg_t cfg_r;
  idw_cfg_t cfg_nxt;
  logic drq_r;
  logic drq_nxt;
  logic [7:0] idx_r;
  logic [7:0] idx_nxt;
  logic [15:0] rdata_r;
  logic [15:0] rdata_nxt;

  // Bus decode
  wire logic wr_ctrl = req.wr && req.addr == A_CTRL;
  wire logic wr_cmd = req.wr && req.addr == A_CMD;
  wire logic start = wr_cmd && req.wdata[7:0] == CMD_IDENTIFY;
  wire logic rd_data = req.rd && req.addr == A_DATA && drq_r;
  wire logic last_rd = rd_data && idx_r == LAST_WORD;
  wire logic [15:0] cur_word = id_word(idx_r, cfg_r);

  // Config writes; msel 3 selects no MDMA mode, leaving the word 63 upper byte zero
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_ctrl) begin
      cfg_nxt.fixed = req.wdata[CTRL_FIXED];
      cfg_nxt.mult = req.wdata[CTRL_MULT];
      cfg_nxt.msel = req.wdata[CTRL_MSEL +: 2];
    end
    if (req.wr) begin
      unique case (req.addr)
        A_DCYL: cfg_nxt.dcyl = req.wdata;
        A_DHEAD: cfg_nxt.dhead = req.wdata;
        A_DSPT: cfg_nxt.dspt = req.wdata;
        A_TOT_LO: cfg_nxt.tot[15:0] = req.wdata;
        A_TOT_HI: cfg_nxt.tot[31:16] = req.wdata;
        A_CCYL: cfg_nxt.ccyl = req.wdata;
        A_CHEAD: cfg_nxt.chead = req.wdata;
        A_CSPT: cfg_nxt.cspt = req.wdata;
        default: ;
      endcase
    end
  end

  // Transfer pointer; a new identify command restarts, so start wins over the last read
  assign drq_nxt = start ? 1'b1 : (last_rd ? 1'b0 : drq_r);
  assign idx_nxt = start ? 8'h00 : (rd_data ? idx_r + 8'h01 : idx_r);

  // Read mux; data stands only in the cycle after the strobe
  assign rdata_nxt = !req.rd ? 16'h0000 :
                     req.addr == A_CTRL ? {12'h000, cfg_r.msel, cfg_r.mult, cfg_r.fixed} :
                     req.addr == A_DATA ? (drq_r ? cur_word : 16'h0000) :
                     req.addr == A_STAT ? {drq_r, 7'h00, idx_r} :
                     req.addr == A_DCYL ? cfg_r.dcyl :
                     req.addr == A_DHEAD ? cfg_r.dhead :
                     req.addr == A_DSPT ? cfg_r.dspt :
                     req.addr == A_TOT_LO ? cfg_r.tot[15:0] :
                     req.addr == A_TOT_HI ? cfg_r.tot[31:16] :
                     req.addr == A_CCYL ? cfg_r.ccyl :
                     req.addr == A_CHEAD ? cfg_r.chead :
                     req.addr == A_CSPT ? cfg_r.cspt : 16'h0000;

  // State registers
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_r <= CFG_RST;
      drq_r <= 1'b0;
      idx_r <= 8'h00;
      rdata_r <= 16'h0000;
    end else begin
      cfg_r <= cfg_nxt;
      drq_r <= drq_nxt;
      idx_r <= idx_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign rdata = rdata_r;
  assign drq = drq_r;

  // Helper: which table word the previous cycle read
  logic hit_r;
  logic [7:0] hit_idx_r;
  logic fixed_q_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hit_r <= 1'b0;
      hit_idx_r <= 8'h00;
      fixed_q_r <= 1'b0;
    end else begin
      hit_r <= rd_data;
      hit_idx_r <= idx_r;
      fixed_q_r <= cfg_r.fixed;
    end
  end

  property p_w0_rem;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd0 && !fixed_q_r |-> rdata == 16'h848a;
  endproperty
  a_w0_rem: assert property (p_w0_rem) else $error("word 0 removable wrong");

  property p_w0_fix;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd0 && fixed_q_r |-> rdata == 16'h045a;
  endproperty
  a_w0_fix: assert property (p_w0_fix) else $error("word 0 fixed wrong");

  property p_serial_pad;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r >= 8'd10 && hit_idx_r <= 8'd15 |-> rdata == 16'h2020;
  endproperty
  a_serial_pad: assert property (p_serial_pad) else $error("serial pad wrong");

  property p_model_pad;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r >= 8'd32 && hit_idx_r <= 8'd46 |-> rdata == 16'h2020;
  endproperty
  a_model_pad: assert property (p_model_pad) else $error("model pad wrong");

  property p_caps;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd49 |-> rdata[13] == 1'b0 && rdata[10] == 1'b0
        && rdata[9] && rdata[8];
  endproperty
  a_caps: assert property (p_caps) else $error("word 49 caps wrong");

  property p_pio51;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd51 |-> rdata[15:8] == 8'h02;
  endproperty
  a_pio51: assert property (p_pio51) else $error("word 51 wrong");

  property p_valid53;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd53 |-> rdata[2:0] == 3'h7;
  endproperty
  a_valid53: assert property (p_valid53) else $error("word 53 wrong");

  property p_mult59;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd59 |-> rdata[15:9] == 7'h00 && rdata[8]
        && rdata[7:0] <= 8'h01;
  endproperty
  a_mult59: assert property (p_mult59) else $error("word 59 wrong");

  property p_sel63;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd63 |-> $onehot0(rdata[15:8]) && rdata[15:11] == 5'h00;
  endproperty
  a_sel63: assert property (p_sel63) else $error("word 63 select wrong");

  property p_start;
    @(posedge clk) disable iff (reset)
      start |=> drq && idx_r == 8'h00;
  endproperty
  a_start: assert property (p_start) else $error("identify start wrong");

  property p_end;
    @(posedge clk) disable iff (reset)
      last_rd && !start |=> !drq ##0 $past(idx_r) == 8'hff;
  endproperty
  a_end: assert property (p_end) else $error("transfer end wrong");

  property p_w163;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd163 |-> rdata == (fixed_q_r ? 16'h0012 : 16'h0000);
  endproperty
  a_w163: assert property (p_w163) else $error("word 163 wrong");

  // Helper: words 65 and 67 as last read; reads run in order, so 66 and 68 follow them
  logic [15:0] w65_r;
  logic [15:0] w67_r;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      w65_r <= 16'h0000;
      w67_r <= 16'h0000;
    end else begin
      if (hit_r && hit_idx_r == 8'd65)
        w65_r <= rdata;
      if (hit_r && hit_idx_r == 8'd67)
        w67_r <= rdata;
    end
  end

  property p_sup63;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd63 |-> rdata[7:3] == 5'h00
        && (!rdata[10] || rdata[2]) && (!rdata[9] || rdata[2:1] != 2'h0)
        && (!rdata[8] || rdata[2:0] != 3'h0);
  endproperty
  a_sup63: assert property (p_sup63) else $error("word 63 support wrong");

  property p_w47;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd47 |-> rdata[7:0] != 8'h00;
  endproperty
  a_w47: assert property (p_w47) else $error("word 47 wrong");

  property p_pio64;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd64 |-> rdata[7:0] == 8'h03;
  endproperty
  a_pio64: assert property (p_pio64) else $error("word 64 wrong");

  property p_dma66;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd66 |-> rdata >= w65_r;
  endproperty
  a_dma66: assert property (p_dma66) else $error("word 66 below word 65");

  property p_pio67;
    @(posedge clk) disable iff (reset)
      hit_r && hit_idx_r == 8'd68 |-> w67_r >= rdata;
  endproperty
  a_pio67: assert property (p_pio67) else $error("word 67 below word 68");

  // A data read with no transfer active must neither answer nor move the pointer
  property p_idle_data;
    @(posedge clk) disable iff (reset)
      req.rd && req.addr == A_DATA && !drq_r |=> rdata == 16'h0000 && $stable(idx_r);
  endproperty
  a_idle_data: assert property (p_idle_data) else $error("idle data read wrong");

  c_start: cover property (@(posedge clk) disable iff (reset) start);
  c_done: cover property (@(posedge clk) disable iff (reset) last_rd);
  c_restart: cover property (@(posedge clk) disable iff (reset) start && drq_r);
  c_fixed: cover property (@(posedge clk) disable iff (reset)
    hit_r && hit_idx_r == 8'd0 && fixed_q_r);

endmodule // idw_table

/* File: design/idw_pkg.sv */
// Package for the identify-device parameter word table
package idw_pkg;
  // Register offsets (word addresses)
  localparam logic [3:0] A_CTRL = 4'h0;
  localparam logic [3:0] A_CMD = 4'h1;
  localparam logic [3:0] A_DATA = 4'h2;
  localparam logic [3:0] A_STAT = 4'h3;
  localparam logic [3:0] A_DCYL = 4'h4;
  localparam logic [3:0] A_DHEAD = 4'h5;
  localparam logic [3:0] A_DSPT = 4'h6;
  localparam logic [3:0] A_TOT_LO = 4'h7;
  localparam logic [3:0] A_TOT_HI = 4'h8;
  localparam logic [3:0] A_CCYL = 4'h9;
  localparam logic [3:0] A_CHEAD = 4'ha;
  localparam logic [3:0] A_CSPT = 4'hb;
  // Control field positions
  localparam int CTRL_FIXED = 0;
  localparam int CTRL_MULT = 1;
  localparam int CTRL_MSEL = 2;
  // Command code and table size
  localparam logic [7:0] CMD_IDENTIFY = 8'hec;
  localparam logic [7:0] LAST_WORD = 8'hff;
  // Fixed word values
  localparam logic [15:0] W0_REMOVABLE = 16'h848a;
  localparam logic [15:0] W0_FIXED = 16'h045a;
  localparam logic [15:0] W47_MULT_MAX = 16'h0001;
  localparam logic [15:0] W49_CAPS = 16'h0b00;
  localparam logic [15:0] W51_PIO = 16'h0200;
  localparam logic [15:0] W53_VALID = 16'h0007;
  localparam logic [7:0] W63_SUPPORT = 8'h07;
  localparam logic [15:0] W64_PIO_ADV = 16'h0003;
  localparam logic [15:0] MDMA_MIN_NS = 16'h0078;
  localparam logic [15:0] MDMA_REC_NS = 16'h0078;
  localparam logic [15:0] PIO_MIN_NS = 16'h0078;
  localparam logic [15:0] PIO_IORDY_NS = 16'h0078;
  localparam logic [15:0] W163_FIXED = 16'h0012;
  localparam logic [15:0] W163_REMOVABLE = 16'h0000;
  localparam logic [7:0] PAD_CHAR = 8'h20;
  // Text fields; contents are arbitrary
  localparam int SER_LEN = 8;
  localparam logic [8*SER_LEN-1:0] SERIAL_TXT = "00000001";
  localparam int MOD_LEN = 10;
  localparam logic [8*MOD_LEN-1:0] MODEL_TXT = "FLASH CARD";
  localparam logic [63:0] FW_TXT = "REV 1.00";
  // Register bus request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } idw_req_t;
  // Software-set geometry and mode
  typedef struct packed {
    logic fixed;
    logic mult;
    logic [1:0] msel;
    logic [15:0] dcyl;
    logic [15:0] dhead;
    logic [15:0] dspt;
    logic [31:0] tot;
    logic [15:0] ccyl;
    logic [15:0] chead;
    logic [15:0] cspt;
  } idw_cfg_t;
  localparam idw_cfg_t CFG_RST = '{fixed: 1'b0, mult: 1'b0, msel: 2'h0,
    dcyl: 16'h03d7, dhead: 16'h0004, dspt: 16'h0020, tot: 32'h0001eb80,
    ccyl: 16'h03d7, chead: 16'h0004, cspt: 16'h0020};
endpackage

/* File: tb/idw_host.sv */
// Host model: register port master that runs identify-device transfers
`timescale 1ns/10ps
module idw_host
  import idw_pkg::*;
(
  // Clock
  input wire logic clk,
  // Register port
  output idw_req_t req,
  input wire logic [15:0] rdata,
  input wire logic drq
);
  logic [15:0] words [256];
  logic [15:0] mdma_ns_r;
  logic go_r;
  initial req = '0;
  // One-cycle write; data scrambled once released so stale values cannot pass
  task automatic bus_wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk);
    req.wr <= 1'b0;
    req.wdata <= ~d;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic bus_rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Start identify, then n back-to-back data reads, word 0 first
  task automatic identify(input int n);
    bus_wr(A_CMD, {8'h00, CMD_IDENTIFY});
    @(posedge clk);
    go_r = drq;
    req <= '{wr: 1'b0, rd: 1'b1, addr: A_DATA, wdata: 16'h0000};
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      if (i == n - 1) req.rd <= 1'b0;
      #1 words[i] = rdata;
    end
    // Never pace DMA faster than the card's minimum cycle
    mdma_ns_r = (words[65] > 16'h0078) ? words[65] : 16'h0078;
  endtask
endmodule // idw_host

/* File: tb/idw_table_tb.sv */
// Self-checking bench for the identify-device parameter table
`timescale 1ns/10ps
module idw_table_tb
  import idw_pkg::*;
;
  logic clk;
  logic reset;
  idw_req_t req;
  logic [15:0] rdata;
  logic [15:0] d;
  logic [16:0] e;
  logic drq;
  int error_cnt;
  int cmp_count;
  logic [15:0] regs [16];

  idw_table idw_table_i (.clk(clk), .reset(reset), .req(req), .rdata(rdata), .drq(drq));
  idw_host idw_host_i (.clk(clk), .req(req), .rdata(rdata), .drq(drq));

  // 100 MHz clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up;
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // Text characters: 0 serial, 1 model, 2 firmware
  function automatic logic [7:0] ch(input int f, input int p);
    if (f == 0) return (p < 20 - SER_LEN) ? 8'h20 : SERIAL_TXT[8 * (19 - p) +: 8];
    if (f == 1) return (p < MOD_LEN) ? MODEL_TXT[8 * (MOD_LEN - 1 - p) +: 8] : 8'h20;
    return FW_TXT[8 * (7 - p) +: 8];
  endfunction

  // Expected word; bit 16 clear where the word is not checked
  function automatic logic [16:0] exp_word(input int w);
    logic [31:0] cap;
    logic [1:0] ms;
    cap = regs[A_CCYL] * regs[A_CHEAD] * regs[A_CSPT];
    ms = regs[A_CTRL][3:2];
    case (w) inside
      0: return {1'b1, regs[A_CTRL][0] ? W0_FIXED : W0_REMOVABLE};
      1: return {1'b1, regs[A_DCYL]};
      3: return {1'b1, regs[A_DHEAD]};
      6: return {1'b1, regs[A_DSPT]};
      7, 61: return {1'b1, regs[A_TOT_HI]};
      8, 60: return {1'b1, regs[A_TOT_LO]};
      [10:19]: return {1'b1, ch(0, 2 * (w - 10)), ch(0, 2 * (w - 10) + 1)};
      [23:26]: return {1'b1, ch(2, 2 * (w - 23)), ch(2, 2 * (w - 23) + 1)};
      [27:46]: return {1'b1, ch(1, 2 * (w - 27)), ch(1, 2 * (w - 27) + 1)};
      47: return {1'b1, W47_MULT_MAX};
      49: return {1'b1, W49_CAPS};
      51: return {1'b1, W51_PIO};
      53: return {1'b1, W53_VALID};
      [54:56]: return {1'b1, regs[w - 45]};
      57: return {1'b1, cap[15:0]};
      58: return {1'b1, cap[31:16]};
      59: return {1'b1, 8'h01, 7'h00, regs[A_CTRL][1]};
      63: return {1'b1, (ms == 2'h3) ? 8'h00 : 8'h01 << ms, W63_SUPPORT};
      64: return {1'b1, W64_PIO_ADV};
      65: return {1'b1, MDMA_MIN_NS};
      66: return {1'b1, MDMA_REC_NS};
      67: return {1'b1, PIO_MIN_NS};
      68: return {1'b1, PIO_IORDY_NS};
      163: return {1'b1, regs[A_CTRL][0] ? 16'h0012 : 16'h0000};
      default: return {1'b1, 16'h0000};
    endcase
  endfunction

  // Hang guard
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    wrap_up();
  end

  // Main sequence: refusals first, then random settings with full identify runs
  initial begin
    error_cnt = 0;
    cmp_count = 0;
    reset = 1'b1;
    d = 16'($urandom(32'h15956b4d));
    repeat (6) @(posedge clk);
    reset <= 1'b0;
    idw_host_i.bus_rd(A_DCYL, d);
    check(d, CFG_RST.dcyl);
    @(posedge clk);
    #1 check(rdata, 16'h0000);
    idw_host_i.bus_wr(4'hc, 16'h5a5a);
    idw_host_i.bus_rd(4'hc, d);
    check(d, 16'h0000);
    idw_host_i.bus_rd(A_DATA, d);
    check(d, 16'h0000);
    idw_host_i.bus_wr(A_CMD, 16'h0020);
    @(posedge clk);
    #1 check({15'h0000, drq}, 16'h0000);
    for (int i = 0; i < 6; i++) begin
      regs[A_CTRL] = {12'h000, 2'(i % 4), 1'($urandom), 1'(i % 2)};
      for (int a = 4; a < 12; a++) regs[a] = 16'($urandom);
      idw_host_i.bus_wr(A_CTRL, regs[A_CTRL]);
      for (int a = 4; a < 12; a++) idw_host_i.bus_wr(4'(a), regs[a]);
      for (int a = 4; a < 12; a++) begin
        idw_host_i.bus_rd(4'(a), d);
        check(d, regs[a]);
      end
      idw_host_i.bus_rd(A_CTRL, d);
      check(d, regs[A_CTRL]);
      // Restart in mid-transfer must begin again at word 0
      if (i == 2) begin
        idw_host_i.identify(5);
        idw_host_i.bus_rd(A_STAT, d);
        check(d, 16'h8005);
      end
      idw_host_i.identify(256);
      check({15'h0000, drq}, 16'h0000);
      check({15'h0000, idw_host_i.go_r}, 16'h0001);
      for (int w = 0; w < 256; w++) begin
        e = exp_word(w);
        if (e[16]) check(idw_host_i.words[w], e[15:0]);
      end
      check(idw_host_i.words[49] & 16'h2700, 16'h0300);
      check(idw_host_i.words[51] & 16'hff00, 16'h0200);
      check(idw_host_i.words[53] & 16'h0007, 16'h0007);
      check(idw_host_i.words[64] & 16'hffff, 16'h0003);
      check({15'h0000, idw_host_i.words[66] < idw_host_i.words[65]}, 16'h0000);
      check({15'h0000, idw_host_i.words[67] < idw_host_i.words[68]}, 16'h0000);
    end
    wrap_up();
  end
endmodule // idw_table_tb
